// ===== pieo_mem_model.sv
// data memory model: combinational read, write on the unit's pulse
`timescale 1ns/1ps
module pieo_mem_model
(
    // clock
    input  wire logic                        sys_clk,
    // memory ports of the unit
    input  wire logic [pieo_pkg::ADDR_W-1:0] mem_raddr,
    output logic [pieo_pkg::DATA_W-1:0]      mem_rdata,
    input  wire pieo_pkg::pieo_mem_wr_type   mem_wr
);
    logic [7:0] mem [4096];
    // bytes seeded from their address, so a misrouted read shows up
    initial for (int i = 0; i < 4096; i++) mem[i] = 8'(i) ^ 8'h5A;
    // indirect places return stored bytes too; the unit must mask them itself
    assign mem_rdata = mem[mem_raddr];
    // full 000h-FFFh write reach
    always @(posedge sys_clk) if (mem_wr.we) mem[mem_wr.addr] <= mem_wr.wdata;
endmodule

// ===== pieo_monitor.sv
// port-level checks of the extended-op unit
`timescale 1ns/1ps
module pieo_monitor
(
    // clock, reset and inputs
    input wire logic                        sys_clk,
    input wire logic                        rstn,
    input wire logic                        extended_set_enable_bit,
    input wire logic                        instr_valid,
    input wire logic [pieo_pkg::WORD_W-1:0] instr_word,
    input wire logic [pieo_pkg::PC_W-1:0]   return_stack_top,
    // outputs watched
    input wire logic [pieo_pkg::ADDR_W-1:0] mem_raddr,
    input wire pieo_pkg::pieo_mem_wr_type   mem_wr,
    input wire logic                        pc_load,
    input wire logic [pieo_pkg::PC_W-1:0]   pc_load_value,
    input wire logic [pieo_pkg::ADDR_W-1:0] file_select_pointer0,
    input wire logic [pieo_pkg::ADDR_W-1:0] stack_pointer_reg,
    input wire logic                        busy,
    input wire logic                        op_done
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // a first word counts only while idle and enabled
    logic       take;
    logic [7:0] hi;
    assign take = instr_valid && extended_set_enable_bit && !busy;
    assign hi   = instr_word[15:8];
    chk_push_store: assert property (take && hi == 8'hFA |=> mem_wr.we
        && mem_wr.addr == $past(stack_pointer_reg) && mem_wr.wdata == $past(instr_word[7:0]))
        else $error("push store wrong");
    chk_push_decr: assert property (take && hi == 8'hFA
        |=> stack_pointer_reg == $past(stack_pointer_reg) - 12'h001) else $error("push decrement");
    chk_sub_ptr: assert property (take && hi == 8'hE9 && instr_word[7:6] == 2'h0
        |=> file_select_pointer0 == $past(file_select_pointer0) - $past(instr_word[5:0]))
        else $error("pointer subtract wrong");
    chk_ret_load: assert property (take && hi == 8'hE9 && instr_word[7:6] == 2'h3 |=> pc_load
        && pc_load_value == return_stack_top
        && stack_pointer_reg == $past(stack_pointer_reg) - $past(instr_word[5:0]))
        else $error("return load wrong");
    chk_ret_two: assert property (take && hi == 8'hE9 && instr_word[7:6] == 2'h3
        |=> busy && !op_done ##1 op_done && !pc_load) else $error("return not two cycles");
    chk_src_addr: assert property (take && hi == 8'hEB
        |-> mem_raddr == stack_pointer_reg + instr_word[6:0]) else $error("source address");
    chk_move_dest: assert property (take && hi == 8'hEB && !instr_word[7] ##1 instr_valid
        |=> mem_wr.we && mem_wr.addr == $past(instr_word[11:0])) else $error("move dest");
    chk_off_idle: assert property (!extended_set_enable_bit && !busy
        |=> !mem_wr.we && !op_done && !pc_load) else $error("acted while disabled");
endmodule
bind pieo_unit pieo_monitor u_mon (.sys_clk, .rstn, .extended_set_enable_bit, .instr_valid,
    .instr_word, .return_stack_top, .mem_raddr, .mem_wr, .pc_load, .pc_load_value,
    .file_select_pointer0, .stack_pointer_reg, .busy, .op_done);

// ===== pieo_pkg.sv
// constants and types of the pointer-indexed extended-op unit
package pieo_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam int WORD_W = 16;
    localparam int PC_W   = 21;
    // opcode upper bytes
    localparam logic [7:0] OP_MOVE_HI   = 8'hEB;
    localparam logic [7:0] OP_PUSH_HI   = 8'hFA;
    localparam logic [7:0] OP_SUB_HI    = 8'hE9;
    localparam logic [3:0] OP_SECOND_HI = 4'hF;
    localparam logic [1:0] SEL_RETURN   = 2'h3;
    localparam int MOVE_KIND_BIT = 7;
    localparam int OFFSET_W      = 7;
    localparam int SUB_LIT_W     = 6;
    // indirect-access register addresses in the special register area
    localparam logic [ADDR_W-1:0] IND0_ADDR = 12'hFEF;
    localparam logic [ADDR_W-1:0] IND1_ADDR = 12'hFE7;
    localparam logic [ADDR_W-1:0] IND2_ADDR = 12'hFDF;
    localparam logic [DATA_W-1:0] IND_READ_VALUE = 8'h00;
    localparam logic [ADDR_W-1:0] PTR_RESET = 12'h000;

    typedef enum logic [1:0] {PIEO_IDLE, PIEO_MOVE_WRITE, PIEO_RETURN_NOP} pieo_state_type;

    typedef struct packed {
        logic              we;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } pieo_mem_wr_type;

    typedef struct packed {
        pieo_state_type    state;
        logic [ADDR_W-1:0] ptr0;
        logic [ADDR_W-1:0] ptr1;
        logic [ADDR_W-1:0] ptr2;
        logic [DATA_W-1:0] src_byte;
        logic              dest_indexed;
        pieo_mem_wr_type   wr;
        logic              pc_load;
        logic              busy;
        logic              done;
    } pieo_regs_type;
endpackage

// ===== pieo_unit.sv
// execution unit for indexed moves, literal push and pointer subtract
`timescale 1ns/1ps
// timing of each operation, counted in clock edges from the edge that takes word one:
//   push literal: write pulse, decremented stack pointer and done one edge later
//   pointer subtract: pointer updated and done one edge later
//   subtract-and-return: pc load and busy one edge later, done the edge after that
//   indexed moves: source read at word one, write pulse and done one edge after word two
// words offered while the unit is busy are ignored, except the second move word
// the unit keeps no status flags, so none can be disturbed by these operations
module pieo_unit
(
    // clock and reset
    input  wire logic                       sys_clk,
    input  wire logic                       rstn,
    // configuration
    input  wire logic                       extended_set_enable_bit,
    // instruction words from the decoder
    input  wire logic                       instr_valid,
    input  wire logic [pieo_pkg::WORD_W-1:0] instr_word,
    // data memory read port, combinational read
    output logic [pieo_pkg::ADDR_W-1:0]     mem_raddr,
    input  wire logic [pieo_pkg::DATA_W-1:0] mem_rdata,
    // data memory write port
    output pieo_pkg::pieo_mem_wr_type       mem_wr,
    // return stack and program counter
    input  wire logic [pieo_pkg::PC_W-1:0]  return_stack_top,
    output logic                            pc_load,
    output logic [pieo_pkg::PC_W-1:0]       pc_load_value,
    // pointer registers and status
    output logic [pieo_pkg::ADDR_W-1:0]     file_select_pointer0,
    output logic [pieo_pkg::ADDR_W-1:0]     file_select_pointer1,
    output logic [pieo_pkg::ADDR_W-1:0]     stack_pointer_reg,
    output logic                            busy,
    output logic                            op_done
);
    pieo_pkg::pieo_regs_type r_q;
    pieo_pkg::pieo_regs_type r_d;
    logic [pieo_pkg::ADDR_W-1:0] src_addr;
    logic [pieo_pkg::ADDR_W-1:0] dst_addr;
    logic [pieo_pkg::ADDR_W-1:0] sub_lit;
    logic                        first_word;

    // indirect registers hide behind fixed addresses, checked on every computed address
    function automatic logic is_indirect(input logic [pieo_pkg::ADDR_W-1:0] a);
        return (a == pieo_pkg::IND0_ADDR) || (a == pieo_pkg::IND1_ADDR)
            || (a == pieo_pkg::IND2_ADDR);
    endfunction

    // address arithmetic wraps at 12 bits so any location is reachable
    assign src_addr = r_q.ptr2 + {5'h00, instr_word[pieo_pkg::OFFSET_W-1:0]};
    assign dst_addr = r_q.dest_indexed
        ? r_q.ptr2 + {5'h00, instr_word[pieo_pkg::OFFSET_W-1:0]}
        : instr_word[pieo_pkg::ADDR_W-1:0];
    assign sub_lit  = {6'h00, instr_word[pieo_pkg::SUB_LIT_W-1:0]};
    assign first_word = instr_valid && extended_set_enable_bit
        && (r_q.state == pieo_pkg::PIEO_IDLE);
    assign mem_raddr = src_addr;

    // next-state logic; no status flag output exists, so flags stay untouched
    always_comb
    begin
        r_d = r_q;
        r_d.wr.we = 1'b0;
        r_d.pc_load = 1'b0;
        r_d.done = 1'b0;
        unique case (r_q.state)
            pieo_pkg::PIEO_IDLE:
            begin
                if (first_word && instr_word[15:8] == pieo_pkg::OP_MOVE_HI)
                begin
                    // read source in cycle one, write waits for word two
                    r_d.src_byte = is_indirect(src_addr) ? pieo_pkg::IND_READ_VALUE
                                                         : mem_rdata;
                    r_d.dest_indexed = instr_word[pieo_pkg::MOVE_KIND_BIT];
                    r_d.state = pieo_pkg::PIEO_MOVE_WRITE;
                    r_d.busy = 1'b1;
                end
                else if (first_word && instr_word[15:8] == pieo_pkg::OP_PUSH_HI)
                begin
                    r_d.wr.we = 1'b1;
                    r_d.wr.addr = r_q.ptr2;
                    r_d.wr.wdata = instr_word[pieo_pkg::DATA_W-1:0];
                    r_d.ptr2 = r_q.ptr2 - 12'h001;
                    r_d.done = 1'b1;
                end
                else if (first_word && instr_word[15:8] == pieo_pkg::OP_SUB_HI)
                begin
                    unique case (instr_word[7:6])
                        2'h0: r_d.ptr0 = r_q.ptr0 - sub_lit;
                        2'h1: r_d.ptr1 = r_q.ptr1 - sub_lit;
                        2'h2: r_d.ptr2 = r_q.ptr2 - sub_lit;
                        default:
                        begin
                            r_d.ptr2 = r_q.ptr2 - sub_lit;
                            r_d.pc_load = 1'b1;
                            r_d.busy = 1'b1;
                            r_d.state = pieo_pkg::PIEO_RETURN_NOP;
                        end
                    endcase
                    if (instr_word[7:6] != pieo_pkg::SEL_RETURN)
                        r_d.done = 1'b1;
                end
            end
            pieo_pkg::PIEO_MOVE_WRITE:
            begin
                // second word arrives; an indirect indexed destination writes nothing
                if (instr_valid)
                begin
                    r_d.wr.we = !(r_q.dest_indexed && is_indirect(dst_addr));
                    r_d.wr.addr = dst_addr;
                    r_d.wr.wdata = r_q.src_byte;
                    r_d.state = pieo_pkg::PIEO_IDLE;
                    r_d.busy = 1'b0;
                    r_d.done = 1'b1;
                end
            end
            pieo_pkg::PIEO_RETURN_NOP:
            begin
                // dead cycle while the new stream is fetched
                r_d.state = pieo_pkg::PIEO_IDLE;
                r_d.busy = 1'b0;
                r_d.done = 1'b1;
            end
        endcase
    end

    // state register, synchronous reset
    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            r_q <= '0;
            r_q.state <= pieo_pkg::PIEO_IDLE;
            r_q.ptr0 <= pieo_pkg::PTR_RESET;
            r_q.ptr1 <= pieo_pkg::PTR_RESET;
            r_q.ptr2 <= pieo_pkg::PTR_RESET;
        end
        else
        begin
            r_q <= r_d;
        end
    end

    // outputs straight from flip-flops; pc value taken from the stack at load time
    // limitation: the return stack must hold its top steady while pc_load is high
    assign mem_wr = r_q.wr;
    assign pc_load = r_q.pc_load;
    assign pc_load_value = return_stack_top;
    assign file_select_pointer0 = r_q.ptr0;
    assign file_select_pointer1 = r_q.ptr1;
    assign stack_pointer_reg = r_q.ptr2;
    assign busy = r_q.busy;
    assign op_done = r_q.done;
endmodule

// ===== tb.sv
// self-checking bench for the extended-op unit
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin num_errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb;
    typedef struct packed {logic [15:0] w; logic we; logic [11:0] sp, p0, p1;} pieo_row_type;
    logic sys_clk, rstn, extended_set_enable_bit, instr_valid, pc_load, busy, op_done;
    logic [15:0] instr_word;
    logic [11:0] mem_raddr, file_select_pointer0, file_select_pointer1, stack_pointer_reg;
    logic [7:0]  mem_rdata;
    logic [20:0] return_stack_top, pc_load_value;
    pieo_pkg::pieo_mem_wr_type mem_wr;
    int num_errors = 0, cmp_count = 0;
    // single-cycle ops back to back; subtracting from zero checks the wrap
    pieo_row_type rows [5] = '{'{16'hE981, 1'b0, 12'hFFF, 12'h000, 12'h000},
        '{16'hFA08, 1'b1, 12'hFFE, 12'h000, 12'h000}, '{16'hE905, 1'b0, 12'hFFE, 12'hFFB, 12'h000},
        '{16'hE94A, 1'b0, 12'hFFE, 12'hFFB, 12'hFF6}, '{16'hE9BF, 1'b0, 12'hFBF, 12'hFFB, 12'hFF6}};
    pieo_unit DUT (.sys_clk, .rstn, .extended_set_enable_bit, .instr_valid, .instr_word,
        .mem_raddr, .mem_rdata, .mem_wr, .return_stack_top, .pc_load, .pc_load_value,
        .file_select_pointer0, .file_select_pointer1, .stack_pointer_reg, .busy, .op_done);
    pieo_mem_model u_mem (.sys_clk, .mem_raddr, .mem_rdata, .mem_wr);
    task automatic put(input logic [15:0] w, input logic v);
        instr_valid = v;
        instr_word  = w;
        @(posedge sys_clk);
        #1;
    endtask
    // two-word move; bounded wait for completion, then the write it made
    task automatic mv(input logic [15:0] w1, w2, input logic we, input logic [19:0] ad);
        int n;
        put(w1, 1'b1);
        put(w2, 1'b1);
        instr_valid = 1'b0;
        for (n = 0; n < 4 && op_done !== 1'b1; n++) put(16'h0000, 1'b0);
        `CHK({mem_wr.we, op_done}, {we, 1'b1})
        if (we) `CHK({mem_wr.addr, mem_wr.wdata}, ad)
        put(16'h0000, 1'b0);
    endtask
    task automatic end_of_test;
        $display("errors %0d, comparisons %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // clock at 100 ns period
    initial
    begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    // watchdog well beyond the few dozen cycles the run needs
    initial
    begin
        #50000;
        num_errors++;
        end_of_test;
    end
    // main sequence; no destination ever names program counter or return-top bytes
    initial
    begin
        {rstn, instr_valid, instr_word} = '0;
        extended_set_enable_bit = 1'b1;
        return_stack_top = 21'h1ABCD;
        repeat (4) put(16'h0000, 1'b0);
        rstn = 1'b1;
        foreach (rows[i])
        begin
            put(rows[i].w, 1'b1);
            `CHK({mem_wr.we, op_done}, {rows[i].we, 1'b1})
            if (rows[i].we) `CHK({mem_wr.addr, mem_wr.wdata}, {rows[i].sp + 12'h001, rows[i].w[7:0]})
            `CHK({stack_pointer_reg, file_select_pointer0, file_select_pointer1}, {rows[i].sp, rows[i].p0, rows[i].p1})
        end
        instr_valid = 1'b0;
        put(16'h0000, 1'b0);
        mv(16'hEB20, 16'hF123, 1'b1, {12'h123, 8'h00});
        mv(16'hEB05, 16'hF200, 1'b1, {12'h200, 8'h9E});
        mv(16'hEB85, 16'hF007, 1'b1, {12'hFC6, 8'h9E});
        mv(16'hEB85, 16'hF030, 1'b0, 20'h00000);
        put(16'hE9C3, 1'b1);
        `CHK({pc_load, pc_load_value, stack_pointer_reg, busy}, {1'b1, 21'h1ABCD, 12'hFBC, 1'b1})
        put(16'h0000, 1'b0);
        `CHK({op_done, pc_load}, 2'h2)
        extended_set_enable_bit = 1'b0;
        put(16'hFA11, 1'b1);
        `CHK({mem_wr.we, op_done, stack_pointer_reg}, {2'h0, 12'hFBC})
        extended_set_enable_bit = 1'b1;
        rstn = 1'b0;
        put(16'h0000, 1'b0);
        `CHK(stack_pointer_reg, 12'h000)
        rstn = 1'b1;
        put(16'hFA44, 1'b1);
        `CHK({mem_wr.we, mem_wr.addr, mem_wr.wdata, stack_pointer_reg}, {1'b1, 12'h000, 8'h44, 12'hFFF})
        put(16'h0000, 1'b0);
        end_of_test;
    end
endmodule
